// >>> logic/usb_ep0_pkg.sv
package usb_ep0_pkg;

	// register byte offsets on the bus
	localparam logic [7:0] OFS_TX_MAX_PAYLOAD = 8'h00;
	localparam logic [7:0] OFS_PERI_CSR = 8'h04;
	localparam logic [7:0] OFS_HOST_CSR = 8'h08;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
	localparam logic [7:0] OFS_MODE = 8'h14;

	// payload limit field
	localparam int PAYLOAD_W = 11;
	localparam logic [PAYLOAD_W-1:0] PAYLOAD_RESET = 11'h000;

	// peripheral endpoint-zero control/status bit positions
	localparam int PC_FLUSH = 8;
	localparam int PC_EARLY_ACK = 7;
	localparam int PC_RX_ACK = 6;
	localparam int PC_STALL_REQ = 5;
	localparam int PC_EARLY_END = 4;
	localparam int PC_LAST_DATA = 3;
	localparam int PC_STALL_SENT = 2;
	localparam int PC_TX_LOADED = 1;
	localparam int PC_RX_WAITING = 0;

	// host endpoint-zero control/status bit positions
	localparam int HC_TOG_UNLOCK = 10;
	localparam int HC_TOGGLE = 9;
	localparam int HC_FLUSH = 8;
	localparam int HC_NAK_TIMEOUT = 7;
	localparam int HC_STATUS = 6;
	localparam int HC_IN_REQ = 5;
	localparam int HC_ERROR = 4;
	localparam int HC_SETUP = 3;
	localparam int HC_STALL_RCVD = 2;
	localparam int HC_TX_LOADED = 1;
	localparam int HC_RX_WAITING = 0;

	// interrupt status / mask bit positions
	localparam int IRQ_W = 4;
	localparam int IRQ_RX = 0;
	localparam int IRQ_TX = 1;
	localparam int IRQ_EARLY_END = 2;
	localparam int IRQ_HOST_ERR = 3;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

	// mode register: bit 0 selects host behaviour
	localparam int MODE_HOST = 0;

	// host retry count before the error flag rises
	localparam logic [1:0] RETRY_LIMIT = 2'h3;
	localparam logic [1:0] RETRY_RESET = 2'h0;

	// ahb-lite constants
	localparam int HTRANS_ACTIVE = 1;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	// events reported by the packet engine, one-cycle pulses
	typedef struct packed {
		logic no_response;
		logic nak_timeout;
		logic stall_received;
		logic stall_sent;
		logic ctrl_end;
		logic tx_done;
		logic rx_packet;
	} link_evt_t;

	// commands presented to the packet engine, all registered
	typedef struct packed {
		logic [PAYLOAD_W-1:0] payload_limit;
		logic host_mode;
		logic tx_packet_loaded;
		logic stall_request;
		logic drop_queued_packet;
		logic in_transfer_request;
		logic setup_token_select;
		logic status_stage_select;
		logic toggle_state;
	} link_ctl_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_READ = 2'b10
	} bus_state_t;

endpackage

// >>> logic/usb_ep0_ctrl.sv
// Notes on behaviour
// R01: payload limit is eleven bits, up to 1024
// R02: software matches limit to descriptor packet size
// R03: flush drops packet, resets pointer, clears ready
// R04: flush ignored when no ready flag set
// R05: early-end ack clears early-end flag, self-clears
// R06: receive ack clears received flag, self-clears
// R07: stall request sends stall, then self-clears
// R08: early end sets flag, interrupts, flushes fifo
// R09: last-data mark set by software, cleared here
// R10: stall sent sets flag; software clears it
// R11: transmit ready cleared after send, interrupts
// R12: received packet sets flag and interrupts
// R13: peripheral register sixteen bits, upper reserved zero
// R14: host register layout, all fields reset zero
// R15: three silent attempts set host error, interrupt
// R16: in request starts transfer, clears on receipt
// R17: toggle writable only while unlock is set
// R18: status stage forces data1; setup token select
// R19: writing zero to command bits does nothing
`timescale 1ns/1ps
`default_nettype none

module usb_ep0_ctrl
	import usb_ep0_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// packet engine side
	input wire link_evt_t link_evt,
	output link_ctl_t link_ctl,
	// interrupt
	output logic irq
);

	// true when the data-phase write targets the given offset
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction
	// bus tracking
	bus_state_t bus_state; // read wait state
	logic dp_valid; // a data phase is pending
	logic dp_write; // pending phase is a write
	logic [7:0] dp_addr; // latched address

	// register state
	logic [PAYLOAD_W-1:0] payload_limit;
	logic host_mode;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;
	logic tx_loaded, rx_waiting, stall_req, stall_sent_flag;
	logic early_end, last_data;
	logic tog_unlock, toggle, nak_timeout, status_sel, in_req;
	logic host_err, setup_sel, stall_rcvd;
	logic [1:0] retry_cnt; // silent attempts so far
	// next values
	logic next_tx_loaded, next_rx_waiting, next_stall_req;
	logic next_stall_sent_flag, next_early_end, next_last_data;
	logic next_tog_unlock, next_toggle, next_nak_timeout, next_status_sel;
	logic next_in_req, next_host_err, next_setup_sel, next_stall_rcvd;
	logic next_drop;
	logic [1:0] next_retry_cnt;
	logic [IRQ_W-1:0] next_irq_status;
	// address phase acceptance
	wire take = hsel & htrans[HTRANS_ACTIVE] & hready;
	// write strobes decoded per register
	wire wr = dp_valid & dp_write;
	wire wr_pay = wr & hit(dp_addr, OFS_TX_MAX_PAYLOAD);
	wire wr_peri = wr & hit(dp_addr, OFS_PERI_CSR);
	wire wr_host = wr & hit(dp_addr, OFS_HOST_CSR);
	wire wr_ists = wr & hit(dp_addr, OFS_IRQ_STATUS);
	wire wr_imsk = wr & hit(dp_addr, OFS_IRQ_MASK);
	wire wr_mode = wr & hit(dp_addr, OFS_MODE);
	// command bits only act when written as one
	wire flush_cmd = (wr_peri & hwdata[PC_FLUSH]) |
		(wr_host & hwdata[HC_FLUSH]); // R19
	wire flush_ok = flush_cmd & (tx_loaded | rx_waiting); // R04
	wire rx_ack = wr_peri & hwdata[PC_RX_ACK]; // R06
	wire early_ack = wr_peri & hwdata[PC_EARLY_ACK]; // R05
	wire tx_set = (wr_peri & hwdata[PC_TX_LOADED]) |
		(wr_host & hwdata[HC_TX_LOADED]);
	// engine events; control end and silence split by mode, rx and tx in both
	wire ev_rx = link_evt.rx_packet;
	wire ev_tx = link_evt.tx_done;
	wire ev_early = link_evt.ctrl_end & ~host_mode & ~last_data; // R08
	wire ev_end = link_evt.ctrl_end & ~host_mode;
	wire ev_silent = link_evt.no_response & host_mode;
	wire ev_err = ev_silent & (retry_cnt == RETRY_LIMIT - 2'h1); // R15
	// readback words, reserved bits zero
	wire [15:0] peri_word = {7'h00, 1'b0, 1'b0, 1'b0, stall_req, early_end,
		last_data, stall_sent_flag, tx_loaded, rx_waiting}; // R13
	wire [15:0] host_word = {5'h00, tog_unlock, toggle, 1'b0, nak_timeout,
		status_sel, in_req, host_err, setup_sel, stall_rcvd, tx_loaded,
		rx_waiting}; // R14
	// read multiplexer; unmapped addresses read zero
	logic [31:0] rd_word;
	always_comb
	begin
		case (dp_addr)
			OFS_TX_MAX_PAYLOAD: rd_word = {21'h000000, payload_limit}; // R01
			OFS_PERI_CSR: rd_word = {16'h0000, peri_word};
			OFS_HOST_CSR: rd_word = {16'h0000, host_word};
			OFS_IRQ_STATUS: rd_word = {28'h0000000, irq_status};
			OFS_IRQ_MASK: rd_word = {28'h0000000, irq_mask};
			OFS_MODE: rd_word = {31'h00000000, host_mode};
			default: rd_word = WORD_ZERO;
		endcase
	end

	// peripheral and shared packet flags
	always_comb
	begin
		// transmit ready: set by software, cleared on send, flush, early end or host error
		next_tx_loaded = tx_loaded;
		if (ev_tx | flush_ok | ev_early | ev_err)
			next_tx_loaded = 1'b0; // R11 R03
		if (tx_set)
			next_tx_loaded = 1'b1; // R11
		// received flag: event wins over ack and flush
		next_rx_waiting = rx_waiting;
		if (rx_ack | flush_ok | ev_early | (wr_host & ~hwdata[HC_RX_WAITING]))
			next_rx_waiting = 1'b0; // R06 R03
		if (ev_rx)
			next_rx_waiting = 1'b1; // R12
		// stall request clears when the handshake has gone out
		next_stall_req = stall_req;
		if (link_evt.stall_sent)
			next_stall_req = 1'b0; // R07
		if (wr_peri & hwdata[PC_STALL_REQ])
			next_stall_req = 1'b1; // R07 R19
		// stall sent: software writes zero to clear, event wins
		next_stall_sent_flag = stall_sent_flag;
		if (wr_peri & ~hwdata[PC_STALL_SENT])
			next_stall_sent_flag = 1'b0; // R10
		if (link_evt.stall_sent)
			next_stall_sent_flag = 1'b1; // R10
		// early end flag
		next_early_end = early_end;
		if (early_ack)
			next_early_end = 1'b0; // R05
		if (ev_early)
			next_early_end = 1'b1; // R08
		// last-data mark lives until the control transfer ends
		next_last_data = last_data;
		if (ev_end)
			next_last_data = 1'b0; // R09
		if (wr_peri & hwdata[PC_LAST_DATA])
			next_last_data = 1'b1; // R09
		// one-cycle pointer reset toward the fifo
		next_drop = flush_ok | ev_early; // R03 R08
	end
	// host-side flags
	always_comb
	begin
		// plain read/write selectors
		next_status_sel = wr_host ? hwdata[HC_STATUS] : status_sel;
		next_setup_sel = wr_host ? hwdata[HC_SETUP] : setup_sel;
		// in request drops once a packet lands or retries run out
		next_in_req = wr_host ? hwdata[HC_IN_REQ] : in_req; // R16
		if ((ev_rx & host_mode) | ev_err)
			next_in_req = 1'b0; // R16
		// sticky flags cleared by writing zero
		next_nak_timeout = nak_timeout;
		if (wr_host & ~hwdata[HC_NAK_TIMEOUT])
			next_nak_timeout = 1'b0;
		if (link_evt.nak_timeout & host_mode)
			next_nak_timeout = 1'b1;
		next_stall_rcvd = stall_rcvd;
		if (wr_host & ~hwdata[HC_STALL_RCVD])
			next_stall_rcvd = 1'b0;
		if (link_evt.stall_received & host_mode)
			next_stall_rcvd = 1'b1;
		next_host_err = host_err;
		if (wr_host & ~hwdata[HC_ERROR])
			next_host_err = 1'b0;
		if (ev_err)
			next_host_err = 1'b1; // R15
		// count silent attempts, restart on a received or sent packet or on error
		next_retry_cnt = retry_cnt;
		if (ev_rx | ev_tx | ev_err)
			next_retry_cnt = RETRY_RESET;
		else if (ev_silent)
			next_retry_cnt = retry_cnt + 2'h1; // R15
		// toggle unlock: armed by a one, spent by the next write
		next_tog_unlock = tog_unlock;
		next_toggle = toggle;
		if (wr_host & tog_unlock)
		begin
			next_toggle = hwdata[HC_TOGGLE]; // R17
			next_tog_unlock = 1'b0; // R17
		end
		else if (wr_host & hwdata[HC_TOG_UNLOCK])
			next_tog_unlock = 1'b1; // R17
		else if (wr_host & hwdata[HC_STATUS] &
			(hwdata[HC_TX_LOADED] | hwdata[HC_IN_REQ]))
			next_toggle = 1'b1; // R18
		else if (wr_host & hwdata[HC_SETUP] & hwdata[HC_TX_LOADED])
			next_toggle = 1'b0; // R18
		else if (host_mode & (ev_rx | ev_tx))
			next_toggle = ~toggle;
	end
	// interrupt status: event set wins over write-one clear
	always_comb
	begin
		next_irq_status = irq_status;
		if (wr_ists)
			next_irq_status = irq_status & ~hwdata[IRQ_W-1:0];
		if (ev_rx)
			next_irq_status[IRQ_RX] = 1'b1; // R12
		if (ev_tx)
			next_irq_status[IRQ_TX] = 1'b1; // R11
		if (ev_early)
			next_irq_status[IRQ_EARLY_END] = 1'b1; // R08
		if (ev_err)
			next_irq_status[IRQ_HOST_ERR] = 1'b1; // R15
	end

	// bus slave; reads take one wait state so a write just before
	// a read is always visible in the returned word
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			bus_state <= BUS_IDLE;
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_addr <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= WORD_ZERO;
		end
		else
		begin
			case (bus_state)
				BUS_IDLE:
				begin
					dp_valid <= take;
					if (take)
					begin
						dp_write <= hwrite;
						dp_addr <= haddr;
					end
					// stall the read for one cycle
					if (take & ~hwrite)
					begin
						bus_state <= BUS_READ;
						hreadyout <= 1'b0;
					end
				end
				BUS_READ:
				begin
					hrdata <= rd_word;
					hreadyout <= 1'b1;
					dp_valid <= 1'b0;
					bus_state <= BUS_IDLE;
				end
				default:
				begin
					bus_state <= BUS_IDLE;
					hreadyout <= 1'b1;
					dp_valid <= 1'b0;
				end
			endcase
		end
	end

	// configuration registers
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			payload_limit <= PAYLOAD_RESET;
			irq_mask <= IRQ_RESET;
			host_mode <= 1'b0;
		end
		else
		begin
			if (wr_pay)
				payload_limit <= hwdata[PAYLOAD_W-1:0]; // R01
			if (wr_imsk)
				irq_mask <= hwdata[IRQ_W-1:0];
			if (wr_mode)
				host_mode <= hwdata[MODE_HOST];
		end
	end

	// endpoint-zero flags, all zero after reset
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tx_loaded <= 1'b0; // R13 R14
			rx_waiting <= 1'b0;
			stall_req <= 1'b0;
			stall_sent_flag <= 1'b0;
			early_end <= 1'b0;
			last_data <= 1'b0;
			tog_unlock <= 1'b0;
			toggle <= 1'b0;
			nak_timeout <= 1'b0;
			status_sel <= 1'b0;
			in_req <= 1'b0;
			host_err <= 1'b0;
			setup_sel <= 1'b0;
			stall_rcvd <= 1'b0;
			retry_cnt <= RETRY_RESET;
			irq_status <= IRQ_RESET;
		end
		else
		begin
			tx_loaded <= next_tx_loaded;
			rx_waiting <= next_rx_waiting;
			stall_req <= next_stall_req;
			stall_sent_flag <= next_stall_sent_flag;
			early_end <= next_early_end;
			last_data <= next_last_data;
			tog_unlock <= next_tog_unlock;
			toggle <= next_toggle;
			nak_timeout <= next_nak_timeout;
			status_sel <= next_status_sel;
			in_req <= next_in_req;
			host_err <= next_host_err;
			setup_sel <= next_setup_sel;
			stall_rcvd <= next_stall_rcvd;
			retry_cnt <= next_retry_cnt;
			irq_status <= next_irq_status;
		end
	end

	// outputs toward the engine mirror the next state, so they
	// line up with the registers software reads back
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			link_ctl <= '0;
			irq <= 1'b0;
		end
		else
		begin
			link_ctl.payload_limit <= wr_pay ? hwdata[PAYLOAD_W-1:0] : payload_limit;
			link_ctl.host_mode <= wr_mode ? hwdata[MODE_HOST] : host_mode;
			link_ctl.tx_packet_loaded <= next_tx_loaded; // R11
			link_ctl.stall_request <= next_stall_req; // R07
			link_ctl.drop_queued_packet <= next_drop; // R03
			link_ctl.in_transfer_request <= next_in_req; // R16
			link_ctl.setup_token_select <= next_setup_sel; // R18
			link_ctl.status_stage_select <= next_status_sel; // R18
			link_ctl.toggle_state <= next_toggle;
			// level interrupt while any unmasked bit is pending
			irq <= |(next_irq_status & irq_mask);
		end
	end

endmodule

`default_nettype wire

// >>> verification/usb_ep0_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// engine stand-in: ends loaded packets and stalls, passes bench events
module ep0_engine_model
	import usb_ep0_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// block controls, bench requests, send delay (0 never sends)
	input wire link_ctl_t ctl,
	input wire link_evt_t req,
	input wire logic [3:0] tx_lat,
	// events into the block
	output link_evt_t evt
);
	logic [3:0] tx_cnt; // cycles a packet has waited
	logic [1:0] st_cnt; // cycles a stall has waited
	// single-cycle pulses; counters restart so one send gives one pulse when the send delay is two or more
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			evt <= '0;
			tx_cnt <= 4'h0;
			st_cnt <= 2'h0;
		end
		else
		begin
			evt <= req;
			tx_cnt <= ctl.tx_packet_loaded ? tx_cnt + 4'h1 : 4'h0;
			st_cnt <= ctl.stall_request ? st_cnt + 2'h1 : 2'h0;
			// packet leaves after the chosen delay
			if (tx_lat != 4'h0 && tx_cnt == tx_lat)
			begin
				evt.tx_done <= 1'b1;
				tx_cnt <= 4'h0;
			end
			// stall handshake goes out, then is reported
			if (st_cnt == 2'h3)
			begin
				evt.stall_sent <= 1'b1;
				st_cnt <= 2'h0;
			end
		end
	end
endmodule
`default_nettype wire

// >>> verification/usb_ep0_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// watches the register bus and the engine link
module ep0_ctrl_checker
	import usb_ep0_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// bus
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	// engine link
	input wire link_evt_t link_evt,
	input wire link_ctl_t link_ctl
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// address phases the slave takes
	wire logic wr_take = hsel && htrans[1] && hready && hwrite;
	wire logic rd_take = hsel && htrans[1] && hready && !hwrite;
	wire logic [PAYLOAD_W-1:0] wd_low = hwdata[PAYLOAD_W-1:0];
	chk_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	chk_write_no_wait: assert property (wr_take |=> hreadyout)
		else $error("write waited");
	chk_read_one_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
		else $error("read wait wrong");
	chk_payload_follows: assert property (
		wr_take && haddr == OFS_TX_MAX_PAYLOAD ##1 1'b1
		|=> link_ctl.payload_limit == $past(wd_low))
		else $error("payload limit wrong");
	chk_tx_done_clears: assert property (
		link_evt.tx_done |=> ##1 !link_ctl.tx_packet_loaded)
		else $error("tx ready kept");
	chk_stall_clears: assert property (
		link_evt.stall_sent && !link_ctl.host_mode
		|=> ##1 !link_ctl.stall_request)
		else $error("stall kept");
	chk_in_req_clears: assert property (
		link_evt.rx_packet && link_ctl.host_mode
		|=> ##1 !link_ctl.in_transfer_request)
		else $error("in request kept");
	chk_flush_pulse: assert property (
		link_ctl.drop_queued_packet |=> !link_ctl.drop_queued_packet)
		else $error("flush not a pulse");
endmodule
bind usb_ep0_ctrl ep0_ctrl_checker u_chk (.sys_clk, .sys_rst, .hsel,
	.haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
	.link_evt, .link_ctl);
`default_nettype wire

// >>> verification/usb_ep0_control_and_tx_maxp_tb.sv
`timescale 1ns/1ps
`default_nettype none
module usb_ep0_control_and_tx_maxp_tb import usb_ep0_pkg::*;;
	localparam logic [31:0] ALL = 32'hffffffff;
	logic sys_clk, sys_rst, hsel, hwrite, hreadyout, hresp, irq;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, q, d;
	logic [3:0] tx_lat;
	link_evt_t evt, req;
	link_ctl_t ctl;
	int miscompares, n_tests, drops, i;
	usb_ep0_ctrl u_dut (.sys_clk, .sys_rst, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
		.hresp, .hrdata, .link_evt(evt), .link_ctl(ctl), .irq);
	ep0_engine_model u_eng (.sys_clk, .sys_rst, .ctl, .req, .tx_lat, .evt);
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// count flush pulses seen by the engine
	always @(posedge sys_clk)
		if (ctl.drop_queued_packet === 1'b1)
			drops++;
	function automatic logic [31:0] b(input int p);
		return 32'h1 << p;
	endfunction
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	// one single transfer; each phase waits for hready, bounded
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		int n;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		for (int p = 0; p < 2; p++)
		begin
			n = 0;
			do
			begin
				@(posedge sys_clk);
				n++;
			end
			while (hreadyout !== 1'b1 && n < 20);
			if (hreadyout !== 1'b1)
			begin
				miscompares++;
				complete_run();
			end
			// only the address edge ends the request; a next call
			// raises hsel itself at the closing edge
			if (p == 0)
			begin
				hsel <= 1'b0;
				htrans <= 2'h0;
				hwdata <= wd;
			end
		end
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		bus(1'b1, a, wd);
	endtask
	// masked read, retried a bounded number of times
	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		int n;
		n = 0;
		do
		begin
			bus(1'b0, a, 32'h0);
			n++;
		end
		while ((q & m) !== e && n < 20);
		chk(q & m, e);
	endtask
	// one engine event pulse
	task automatic ev(input logic [6:0] e);
		req <= link_evt_t'(e);
		@(posedge sys_clk);
		req <= '0;
		repeat (2) @(posedge sys_clk);
	endtask
	initial
	begin
		sys_rst = 1'b1;
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h0;
		hwdata = 32'h0;
		req = '0;
		tx_lat = 4'h0;
		q = $urandom(32'h55aa25b6);
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		// unmapped write is dropped; all offsets read zero
		wr(8'h18, ALL);
		for (i = 0; i < 7; i++)
			rd(8'(i * 4), ALL, 32'h0);
		// payload field: corners then random words
		for (i = 0; i < 8; i++)
		begin
			// field kept within the largest legal packet
			d = (i == 0) ? ~32'h3ff : (i == 1) ? 32'h40 :
				(($urandom & ~32'h7ff) | $urandom_range(1024, 0));
			wr(OFS_TX_MAX_PAYLOAD, d);
			rd(OFS_TX_MAX_PAYLOAD, ALL, d & 32'h7ff);
		end
		// loaded packet, flushed once, second flush idle
		wr(OFS_PERI_CSR, b(PC_TX_LOADED));
		rd(OFS_PERI_CSR, ALL, b(PC_TX_LOADED));
		wr(OFS_PERI_CSR, b(PC_FLUSH));
		rd(OFS_PERI_CSR, ALL, 32'h0);
		wr(OFS_PERI_CSR, b(PC_FLUSH));
		repeat (2) @(posedge sys_clk);
		chk(32'(drops), 32'h1);
		// masked completion, then unmask, then clear
		tx_lat <= 4'($urandom_range(3, 15));
		wr(OFS_IRQ_MASK, 32'h0);
		wr(OFS_PERI_CSR, b(PC_TX_LOADED));
		rd(OFS_PERI_CSR, ALL, 32'h0);
		rd(OFS_IRQ_STATUS, ALL, b(IRQ_TX));
		chk(32'(irq), 32'h0);
		wr(OFS_IRQ_MASK, 32'hf);
		repeat (2) @(posedge sys_clk);
		chk(32'(irq), 32'h1);
		wr(OFS_IRQ_STATUS, 32'hf);
		repeat (2) @(posedge sys_clk);
		chk(32'(irq), 32'h0);
		tx_lat <= 4'h0;
		// received packet survives zero writes, ack clears it
		ev(7'h01);
		rd(OFS_IRQ_STATUS, ALL, b(IRQ_RX));
		wr(OFS_PERI_CSR, 32'hfffffe00);
		rd(OFS_PERI_CSR, ALL, b(PC_RX_WAITING));
		wr(OFS_PERI_CSR, b(PC_RX_ACK));
		rd(OFS_PERI_CSR, ALL, 32'h0);
		wr(OFS_IRQ_STATUS, 32'hf);
		// stall goes out, request drops, sent flag stays until cleared
		wr(OFS_PERI_CSR, b(PC_STALL_REQ));
		rd(OFS_PERI_CSR, ALL, b(PC_STALL_SENT));
		wr(OFS_PERI_CSR, 32'h0);
		rd(OFS_PERI_CSR, ALL, 32'h0);
		// control end before last-data mark: early end with flush
		wr(OFS_PERI_CSR, b(PC_TX_LOADED));
		ev(7'h04);
		rd(OFS_PERI_CSR, ALL, b(PC_EARLY_END));
		rd(OFS_IRQ_STATUS, b(IRQ_EARLY_END), b(IRQ_EARLY_END));
		chk(32'(drops), 32'h2);
		wr(OFS_PERI_CSR, b(PC_EARLY_ACK));
		rd(OFS_PERI_CSR, ALL, 32'h0);
		// same end with the mark set is regular
		wr(OFS_PERI_CSR, b(PC_LAST_DATA) | b(PC_TX_LOADED));
		ev(7'h04);
		rd(OFS_PERI_CSR, b(PC_EARLY_END), 32'h0);
		wr(OFS_PERI_CSR, b(PC_FLUSH));
		// host: in request ends on data, three silences give error
		wr(OFS_MODE, 32'h1);
		wr(OFS_HOST_CSR, b(HC_IN_REQ));
		ev(7'h01);
		d = b(HC_IN_REQ) | b(HC_RX_WAITING);
		rd(OFS_HOST_CSR, d, b(HC_RX_WAITING));
		for (i = 1; i < 4; i++)
		begin
			ev(7'h40);
			rd(OFS_HOST_CSR, b(HC_ERROR), (i == 3) ? b(HC_ERROR) : 0);
		end
		rd(OFS_IRQ_STATUS, b(IRQ_HOST_ERR), b(IRQ_HOST_ERR));
		// nak timeout and received stall show in the host word
		ev(7'h30);
		d = b(HC_NAK_TIMEOUT) | b(HC_STALL_RCVD);
		rd(OFS_HOST_CSR, d, d);
		// toggle loads only behind the unlock, which then drops
		d = b(HC_TOGGLE) | b(HC_TOG_UNLOCK);
		wr(OFS_HOST_CSR, b(HC_TOG_UNLOCK));
		wr(OFS_HOST_CSR, 32'h0);
		wr(OFS_HOST_CSR, b(HC_TOGGLE));
		rd(OFS_HOST_CSR, d, 32'h0);
		wr(OFS_HOST_CSR, b(HC_STATUS) | b(HC_TX_LOADED));
		rd(OFS_HOST_CSR, b(HC_TOGGLE), b(HC_TOGGLE));
		chk(32'({ctl.host_mode, ctl.status_stage_select,
			ctl.toggle_state}), 32'h7);
		// setup token with a loaded packet restarts at data0
		wr(OFS_HOST_CSR, b(HC_SETUP) | b(HC_TX_LOADED));
		rd(OFS_HOST_CSR, b(HC_SETUP) | b(HC_TOGGLE), b(HC_SETUP));
		chk(32'({ctl.setup_token_select, ctl.toggle_state}), 32'h2);
		complete_run();
	end
endmodule
`default_nettype wire
